// ---- wwcm_defines.svh ----
`ifndef WWCM_DEFINES_SVH
`define WWCM_DEFINES_SVH

// service register field positions
`define WWCM_SEL_HI 7
`define WWCM_SEL_LO 6
`define WWCM_KEY_HI 5
`define WWCM_KEY_LO 1
`define WWCM_CME_BIT 0

// service register values
`define WWCM_KEY 5'h0C
`define WWCM_KEY_READ 5'h00
`define WWCM_SEL_RST 2'h3
`define WWCM_CME_RST 1'b1

// window limits in idle timer clocks
`define WWCM_LOWER_LIM 17'h00800
`define WWCM_UPPER_BASE 17'h02000
`define WWCM_CNT_ZERO 17'h00000
`define WWCM_CNT_ONE 17'h00001

// fault release delay (24 cycles, inside 16 to 32)
`define WWCM_REL_CNT 6'h18
`define WWCM_REL_ZERO 6'h00
`define WWCM_REL_ONE 6'h01

// clock monitor slow limit: 1000 us, between 200 us (5 kHz) and 100 ms (10 Hz)
`define WWCM_CM_LIMIT_US 1000
`define WWCM_CLK_MHZ 125

`endif

// ---- wwcm_pkg.sv ----
package wwcm_pkg;

  // gray coded along run, fault, hold, release
  typedef enum logic [1:0] {
    wwcm_st_run = 2'b00,
    wwcm_st_fault = 2'b01,
    wwcm_st_hold = 2'b11,
    wwcm_st_wait_high = 2'b10
  } wwcm_state_t;

endpackage : wwcm_pkg

// ---- wwcm_top.sv ----
`timescale 1ns/10ps
`include "wwcm_defines.svh"
// Operation
// (R1) window select codes 0..3 give upper limit 8k,16k,32k,64k; lower limit 2048
// (R2) during reset both detectors are held inactive and raise no error
// (R3) after reset window select is 11 (65536) and clock monitor enabled
// (R4) only first key-matching write loads window select and monitor enable until reset
// (R5) later writes must match window, key and monitor bits; mismatch is an error
// (R6) no valid service before the upper limit raises a watchdog error
// (R7) a service before the lower limit since last restart is an error
// (R8) entering boot rom suppresses lower check and services immediately
// (R9) returning from boot rom services and re-enables the lower check; the code keeps it off until the first user service after return
// (R10) on error drive fault low, hold 16-32 cycles after pin sensed low, release
// (R11) the window restarts when the fault pin returns high after an error pulse
// (R12) service writes while fault output is active are ignored
// (R13) enabled clock monitor holds fault low while clock slow, releases 16-32 cycles after
// (R14) monitor never flags above 5 kHz, always flags below 10 Hz or stopped clock
// (R15) reads of the service register return zeros in the key field
// (R16) watchdog detector is suspended during halt and idle
// (R17) clock monitor stays active during halt and idle
// (R18) on halt exit the window restarts at its selected value
// (R19) on idle exit a hardware service restarts the window with its lower limit
// (R20) first service after reset is accepted anywhere, even inside the first 2048
// (R21) watchdog and fault pin active only while the option bit reads 0
// (R22) service register: select bits 7:6, key bits 5:1, monitor enable bit 0
// (R23) sensed fault pin level is synchronised before use
module wwcm_top
  import wwcm_pkg::*;
#(
  parameter int CM_W = 17,
  parameter int CM_LIMIT_CYC = `WWCM_CM_LIMIT_US * `WWCM_CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic option_wd_disable,
  input wire logic idle_timer_tick,
  input wire logic instr_clk_tick,
  input wire logic svc_wr,
  input wire logic [7:0] svc_wdata,
  output logic [7:0] svc_rdata,
  input wire logic boot_rom_enter,
  input wire logic boot_rom_exit,
  input wire logic halt_mode,
  input wire logic idle_mode,
  input wire logic fault_pin_in,
  output logic fault_out_n,
  output logic fault_oe
);

  localparam logic [CM_W-1:0] CM_LIMIT = CM_LIMIT_CYC[CM_W-1:0];
  localparam logic [CM_W-1:0] CM_ONE = {{(CM_W-1){1'b0}}, 1'b1};

  wwcm_state_t state;
  wwcm_state_t next_state;
  logic [1:0] win_sel;
  logic cm_en;
  logic first_done;
  logic lower_inhibit;
  logic in_boot;
  logic [16:0] win_cnt;
  logic [5:0] hold_cnt;
  logic [5:0] rec_cnt;
  logic [CM_W-1:0] cm_cnt;
  logic cm_drive;
  logic pin_s1;
  logic pin_s2;
  logic halt_d;
  logic idle_d;

  // decode
  wire wd_en = ~option_wd_disable; // R21
  wire suspended = halt_mode | idle_mode; // R16
  wire halt_exit = halt_d & ~halt_mode;
  wire idle_exit = idle_d & ~idle_mode;
  wire pin_low = ~pin_s2;
  wire fault_active = fault_oe | pin_low;
  wire [1:0] wr_sel = svc_wdata[`WWCM_SEL_HI:`WWCM_SEL_LO]; // R22
  wire [4:0] wr_key = svc_wdata[`WWCM_KEY_HI:`WWCM_KEY_LO]; // R22
  wire wr_cme = svc_wdata[`WWCM_CME_BIT]; // R22
  wire key_ok = (wr_key == `WWCM_KEY);
  wire full_ok = key_ok & (wr_sel == win_sel) & (wr_cme == cm_en); // R5
  wire [16:0] upper_lim = `WWCM_UPPER_BASE << win_sel; // R1
  wire too_early = first_done & ~lower_inhibit & (win_cnt < `WWCM_LOWER_LIM); // R7 R20
  wire svc_take = svc_wr & wd_en & ~fault_active & ~suspended & (state == wwcm_st_run); // R12 R16
  wire svc_good = svc_take & (first_done ? (full_ok & ~too_early) : key_ok); // R4 R5 R7
  wire svc_bad = svc_take & ~svc_good; // R5 R7
  wire first_load = svc_take & ~first_done & key_ok; // R4
  wire hw_service = boot_rom_enter | boot_rom_exit | idle_exit | halt_exit; // R8 R9 R18 R19
  wire expire = wd_en & (state == wwcm_st_run) & (win_cnt >= upper_lim); // R6
  wire wd_error = svc_bad | expire;
  wire pin_back = (state == wwcm_st_wait_high) & ~pin_low; // R11
  wire restart = svc_good | hw_service | pin_back;
  wire win_step = idle_timer_tick & ~suspended & (win_cnt < upper_lim); // R16
  wire hold_done = (hold_cnt == `WWCM_REL_CNT);
  wire cm_act = wd_en & cm_en;
  wire cm_slow = (cm_cnt == CM_LIMIT); // R14
  wire rec_done = (rec_cnt == `WWCM_REL_CNT);
  wire next_drive = wd_en & ((next_state == wwcm_st_fault) | (next_state == wwcm_st_hold) | cm_drive);

  // watchdog fault sequence
  always_comb begin
    next_state = state;
    unique case (state)
      wwcm_st_run: begin
        if (wd_error) begin
          next_state = wwcm_st_fault; // R10
        end
      end
      wwcm_st_fault: begin
        if (pin_low) begin
          next_state = wwcm_st_hold; // R10
        end
      end
      wwcm_st_hold: begin
        if (hold_done) begin
          next_state = wwcm_st_wait_high; // R10
        end
      end
      wwcm_st_wait_high: begin
        if (~pin_low) begin
          next_state = wwcm_st_run; // R11
        end
      end
    endcase
    if (!wd_en) begin
      next_state = wwcm_st_run;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= wwcm_st_run; // R2
    end else begin
      state <= next_state;
    end
  end

  // pin synchroniser
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
    end else begin
      pin_s1 <= fault_pin_in; // R23
      pin_s2 <= pin_s1; // R23
    end
  end

  // low power mode edges
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      halt_d <= 1'b0;
      idle_d <= 1'b0;
    end else begin
      halt_d <= halt_mode;
      idle_d <= idle_mode;
    end
  end

  // configuration held from the first valid write
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      win_sel <= `WWCM_SEL_RST; // R3
      cm_en <= `WWCM_CME_RST; // R3
      first_done <= 1'b0;
    end else if (first_load) begin
      win_sel <= wr_sel; // R4
      cm_en <= wr_cme; // R4
      first_done <= 1'b1; // R4
    end
  end

  // boot rom lower window inhibit
  // first user service after return to flash may come anytime
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lower_inhibit <= 1'b0;
      in_boot <= 1'b0;
    end else if (boot_rom_enter) begin
      lower_inhibit <= 1'b1; // R8
      in_boot <= 1'b1; // R8
    end else if (boot_rom_exit) begin
      lower_inhibit <= 1'b1; // R9
      in_boot <= 1'b0; // R9
    end else if (svc_good && !in_boot) begin
      lower_inhibit <= 1'b0; // R9
    end
  end

  // window counter in idle timer clocks
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      win_cnt <= `WWCM_CNT_ZERO;
    end else if (!wd_en || restart || state != wwcm_st_run) begin
      win_cnt <= `WWCM_CNT_ZERO; // R5 R11 R18 R19
    end else if (win_step) begin
      win_cnt <= win_cnt + `WWCM_CNT_ONE; // R6
    end
  end

  // release delay after pin sensed low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold_cnt <= `WWCM_REL_ZERO;
    end else if (state != wwcm_st_hold) begin
      hold_cnt <= `WWCM_REL_ZERO;
    end else if (!hold_done) begin
      hold_cnt <= hold_cnt + `WWCM_REL_ONE; // R10
    end
  end

  // clock monitor: ref cycles since last instruction clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cm_cnt <= '0; // R2
    end else if (instr_clk_tick) begin
      cm_cnt <= '0; // R14
    end else if (!cm_slow) begin
      cm_cnt <= cm_cnt + CM_ONE; // R14 R17
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rec_cnt <= `WWCM_REL_ZERO;
    end else if (cm_slow || !cm_drive) begin
      rec_cnt <= `WWCM_REL_ZERO;
    end else if (instr_clk_tick && !rec_done) begin
      rec_cnt <= rec_cnt + `WWCM_REL_ONE; // R13
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cm_drive <= 1'b0; // R2
    end else if (!cm_act) begin
      cm_drive <= 1'b0;
    end else if (cm_slow) begin
      cm_drive <= 1'b1; // R13 R17
    end else if (rec_done) begin
      cm_drive <= 1'b0; // R13
    end
  end

  // pin and read data outputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fault_oe <= 1'b0; // R2
      fault_out_n <= 1'b1;
    end else begin
      fault_oe <= next_drive; // R10 R13 R21
      fault_out_n <= ~next_drive;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      svc_rdata <= {`WWCM_SEL_RST, `WWCM_KEY_READ, `WWCM_CME_RST};
    end else begin
      svc_rdata <= {win_sel, `WWCM_KEY_READ, cm_en}; // R15
    end
  end

  // checks
  property p_key_hidden;
    @(posedge ref_clk) disable iff (!rstn)
    svc_rdata[`WWCM_KEY_HI:`WWCM_KEY_LO] == `WWCM_KEY_READ;
  endproperty
  a_key_hidden: assert property (p_key_hidden) else $error("key field not zero on read"); // R15

  property p_bad_service;
    @(posedge ref_clk) disable iff (!rstn)
    svc_bad |-> ##1 fault_oe && !fault_out_n;
  endproperty
  a_bad_service: assert property (p_bad_service) else $error("bad service did not drive fault"); // R5

  property p_expire;
    @(posedge ref_clk) disable iff (!rstn)
    expire |=> state == wwcm_st_fault;
  endproperty
  a_expire: assert property (p_expire) else $error("upper limit did not raise error"); // R6

  property p_early;
    @(posedge ref_clk) disable iff (!rstn)
    svc_take && first_done && !lower_inhibit && win_cnt < `WWCM_LOWER_LIM |=> state == wwcm_st_fault;
  endproperty
  a_early: assert property (p_early) else $error("early service not flagged"); // R7

  property p_ignore;
    @(posedge ref_clk) disable iff (!rstn)
    svc_wr && fault_oe && state == wwcm_st_run && !hw_service && !wd_en == 1'b0 && !expire
      && win_cnt > `WWCM_CNT_ZERO |=> state == wwcm_st_run && win_cnt != `WWCM_CNT_ZERO;
  endproperty
  a_ignore: assert property (p_ignore) else $error("write during active fault not ignored"); // R12

  property p_hold_len;
    @(posedge ref_clk) disable iff (!rstn)
    state == wwcm_st_wait_high && $past(state) == wwcm_st_hold |-> $past(hold_cnt) == `WWCM_REL_CNT;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("release delay wrong"); // R10

  property p_first;
    @(posedge ref_clk) disable iff (!rstn)
    first_load |=> first_done && win_sel == $past(wr_sel) && win_cnt == `WWCM_CNT_ZERO;
  endproperty
  a_first: assert property (p_first) else $error("first service not accepted"); // R20

  property p_suspend;
    @(posedge ref_clk) disable iff (!rstn)
    suspended && wd_en && state == wwcm_st_run && !restart |=> win_cnt == $past(win_cnt);
  endproperty
  a_suspend: assert property (p_suspend) else $error("window counted while suspended"); // R16

  property p_cm_slow;
    @(posedge ref_clk) disable iff (!rstn)
    cm_act && cm_slow |-> ##[1:2] fault_oe;
  endproperty
  a_cm_slow: assert property (p_cm_slow) else $error("slow clock not flagged"); // R13

  property p_boot;
    @(posedge ref_clk) disable iff (!rstn)
    boot_rom_enter && wd_en && state == wwcm_st_run |=> lower_inhibit && win_cnt == `WWCM_CNT_ZERO;
  endproperty
  a_boot: assert property (p_boot) else $error("boot entry did not service"); // R8

  property p_disabled;
    @(posedge ref_clk) disable iff (!rstn)
    !wd_en |=> !fault_oe && fault_out_n;
  endproperty
  a_disabled: assert property (p_disabled) else $error("fault driven while disabled"); // R21

  property p_pin_back;
    @(posedge ref_clk) disable iff (!rstn)
    pin_back |=> state == wwcm_st_run && win_cnt == `WWCM_CNT_ZERO;
  endproperty
  a_pin_back: assert property (p_pin_back) else $error("window not restarted after fault pulse"); // R11

  property p_boot_exit;
    @(posedge ref_clk) disable iff (!rstn)
    boot_rom_exit && !boot_rom_enter && wd_en && state == wwcm_st_run |=> lower_inhibit && !in_boot
      && win_cnt == `WWCM_CNT_ZERO;
  endproperty
  a_boot_exit: assert property (p_boot_exit) else $error("boot return did not service"); // R9

  property p_idle_exit;
    @(posedge ref_clk) disable iff (!rstn)
    idle_exit && wd_en && state == wwcm_st_run |=> win_cnt == `WWCM_CNT_ZERO;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle exit did not service"); // R19

endmodule : wwcm_top

// ---- wwcm_pin_model.sv ----
`timescale 1ns/10ps
module wwcm_pin_model (
  input wire logic ref_clk,
  input wire logic fault_out_n,
  input wire logic fault_oe,
  output logic fault_pin,
  output logic [15:0] pulse_count
);
  logic pin_q = 1'b1;
  // weak pull-up: a released pin reads high
  assign fault_pin = fault_oe ? fault_out_n : 1'b1;
  // external reset circuit counts each low pulse, never reset itself
  logic [15:0] falls = 16'h0000;
  assign pulse_count = falls;
  always @(posedge ref_clk) begin
    pin_q <= fault_pin;
    if (pin_q && !fault_pin) begin
      falls <= falls + 16'h0001;
    end
  end
endmodule : wwcm_pin_model

// ---- windowed_watchdog_clock_monitor_test.sv ----
`timescale 1ns/10ps
module windowed_watchdog_clock_monitor_test;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic option_wd_disable = 1'b0;
  logic idle_timer_tick = 1'b0;
  logic instr_clk_tick = 1'b0;
  logic svc_wr = 1'b0;
  logic [7:0] svc_wdata = 8'h00;
  logic boot_rom_enter = 1'b0;
  logic boot_rom_exit = 1'b0;
  logic halt_mode = 1'b0;
  logic idle_mode = 1'b0;
  logic cm_run = 1'b1;
  logic [7:0] svc_rdata;
  logic fault_out_n, fault_oe, fault_pin;
  logic [15:0] pulse_count;
  int fail_count = 0;
  int n_tests = 0;
  int cfg = -1;
  bit [31:0] seed = 32'h00004819;
  bit exp_q[$];

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    instr_clk_tick <= cm_run;
    idle_timer_tick <= 1'b1;
  end

  wwcm_top #(.CM_LIMIT_CYC(200)) dut (.ref_clk, .rstn, .option_wd_disable, .idle_timer_tick, .instr_clk_tick,
    .svc_wr, .svc_wdata, .svc_rdata, .boot_rom_enter, .boot_rom_exit, .halt_mode, .idle_mode,
    .fault_pin_in(fault_pin), .fault_out_n, .fault_oe);
  wwcm_pin_model pin_model (.ref_clk, .fault_out_n, .fault_oe, .fault_pin, .pulse_count);

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt

  task automatic wait_oe(input logic lvl, input int w, output int n);
    n = 0;
    while (fault_oe !== lvl && n < w) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask : wait_oe

  // expect a fault pulse or none; a write during the pulse must be ignored
  task automatic pulse(input bit e, input int w);
    int n;
    wait_oe(1'b1, w, n);
    chk("fault_oe", 16'(e), 16'(fault_oe));
    if (e) begin
      chk("fault_out_n", 16'h0000, 16'(fault_out_n));
      exp_q.push_back(1'b1);
      @(posedge ref_clk);
      svc_wr <= 1'b1;
      svc_wdata <= 8'h00;
      @(posedge ref_clk);
      svc_wr <= 1'b0;
      wait_oe(1'b0, 100, n);
      chk("hold_len_ok", 16'h0001, 16'(n >= 16 && n <= 31));
      wt(8);
      #1;
      chk("no_retrigger", 16'h0000, 16'(fault_oe));
    end
  endtask : pulse

  task automatic svc(input logic [7:0] d, input int age, input bit boot);
    bit e;
    e = d[5:1] != 5'h0C || (cfg >= 0 && (d != cfg[7:0] || (age < 2048 && !boot)));
    e = e && !option_wd_disable;
    if (cfg < 0 && !e) cfg = int'(d);
    @(posedge ref_clk);
    svc_wr <= 1'b1;
    svc_wdata <= d;
    @(posedge ref_clk);
    svc_wr <= 1'b0;
    pulse(e, 4);
  endtask : svc

  task automatic do_reset();
    @(posedge ref_clk);
    rstn <= 1'b0;
    wt(5);
    #1;
    chk("oe_in_reset", 16'h0000, 16'(fault_oe));
    chk("rdata_reset", 16'h00C1, 16'(svc_rdata));
    @(posedge ref_clk);
    rstn <= 1'b1;
    cfg = -1;
  endtask : do_reset

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    #(95000 * 8);
    fail_count++;
    stop_test();
  end

  initial begin
    int n;
    logic [7:0] m;
    do_reset();
    wt(10);
    svc(8'h19, 10, 0);
    chk("rdata_cfg", 16'h0001, 16'(svc_rdata));
    svc(8'h19, 20, 0);
    wt(2100);
    svc(8'h19, 2100, 0);
    for (int i = 0; i < 3; i++) begin
      wt(2100);
      m = rnd();
      m = (i == 0) ? {m[1:0] | 2'h1, 6'h00} : (i == 1) ? {2'h0, m[4:0] | 5'h01, 1'b0} : 8'h01;
      svc(8'h19 ^ m, 2100, 0);
    end
    for (int j = 0; j < 2; j++) begin
      wt(2100);
      @(posedge ref_clk);
      halt_mode <= (j == 0);
      idle_mode <= (j == 1);
      wt(6500);
      #1;
      chk("suspended", 16'h0000, 16'(fault_oe));
      @(posedge ref_clk);
      halt_mode <= 1'b0;
      idle_mode <= 1'b0;
      wt(20);
      svc(8'h19, 20, 0);
    end
    @(posedge ref_clk);
    boot_rom_enter <= 1'b1;
    @(posedge ref_clk);
    boot_rom_enter <= 1'b0;
    wt(10);
    svc(8'h19, 10, 1);
    wt(2100);
    @(posedge ref_clk);
    boot_rom_exit <= 1'b1;
    @(posedge ref_clk);
    boot_rom_exit <= 1'b0;
    wt(10);
    svc(8'h19, 10, 1);
    svc(8'h19, 10, 0);
    wt(8100);
    #1;
    chk("before_limit", 16'h0000, 16'(fault_oe));
    pulse(1'b1, 150);
    @(posedge ref_clk);
    cm_run <= 1'b0;
    halt_mode <= 1'b1;
    wt(150);
    wait_oe(1'b1, 80, n);
    chk("cm_fault", 16'h0001, 16'(fault_oe));
    exp_q.push_back(1'b1);
    wt(300);
    #1;
    chk("cm_hold", 16'h0001, 16'(fault_oe));
    @(posedge ref_clk);
    cm_run <= 1'b1;
    halt_mode <= 1'b0;
    wt(2);
    svc_wr <= 1'b1;
    svc_wdata <= 8'h00;
    @(posedge ref_clk);
    svc_wr <= 1'b0;
    wait_oe(1'b0, 100, n);
    chk("cm_release_ok", 16'h0001, 16'(n >= 15 && n <= 31));
    wt(20);
    @(posedge ref_clk);
    option_wd_disable <= 1'b1;
    wt(2);
    svc(8'h00, 20, 0);
    @(posedge ref_clk);
    option_wd_disable <= 1'b0;
    for (int s = 1; s < 3; s++) begin
      do_reset();
      wt(10);
      svc({2'(s), 6'h19}, 10, 0);
      chk("rdata_sel", {8'h00, 2'(s), 6'h01}, 16'(svc_rdata));
      wt((8192 << s) - 100);
      #1;
      chk("before_limit", 16'h0000, 16'(fault_oe));
      pulse(1'b1, 200);
    end
    wt(4);
    chk("pulses", 16'(exp_q.size()), pulse_count);
    stop_test();
  end
endmodule : windowed_watchdog_clock_monitor_test
